// File: core/lic_consts.svh
// constants of the charger control block: timing, encodings, reset values
`ifndef LIC_CONSTS_SVH
`define LIC_CONSTS_SVH
`define LIC_CLK_PERIOD_NS 25
`define LIC_SC_DGL_NS     250000
`define LIC_SC_REC_NS     64000000
`define LIC_DET_NS        250000000
`define LIC_BLINK_HALF_NS 250000000
`define LIC_TMR_W         24
`define LIC_LIM_LOW       2'h0
`define LIC_LIM_HIGH      2'h1
`define LIC_LIM_RES       2'h2
`define LIC_LIM_SUSP      2'h3
`define LIC_RST_OFF       1'b0
`endif

// File: core/lic_pkg.sv
// types shared by the charger control block
package lic_pkg;
   // synchronised pin and comparator inputs
   typedef struct packed {
      logic input_present;
      logic limit_sel_a;
      logic limit_sel_b;
      logic charge_enable_n;
      logic termination_disable;
      logic battery_disconnect;
      logic vin_at_droop;
      logic out_at_share;
      logic out_below_sup_enter;
      logic out_above_sup_exit;
      logic out_short;
      logic battery_above_short_chk;
      logic battery_above_pre_exit;
      logic battery_at_reg;
      logic current_at_term;
      logic battery_below_recharge;
      logic battery_below_3v2;
      logic thermal_reg;
      logic temp_pin_open_or_high;
      logic term_pin_open;
      logic fast_exceeds_limit;
      logic safety_timer_expired;
   } lic_cmp_s;

   typedef enum logic [1:0] {
      LIC_LIM_LOW_E  = 2'h0,
      LIC_LIM_HIGH_E = 2'h1,
      LIC_LIM_RES_E  = 2'h2,
      LIC_LIM_SUSP_E = 2'h3
   } lic_lim_e;

   typedef enum logic [8:0] {
      LIC_PH_IDLE  = 9'h001,
      LIC_PH_SHORT = 9'h002,
      LIC_PH_PRE   = 9'h004,
      LIC_PH_FAST  = 9'h008,
      LIC_PH_CV    = 9'h010,
      LIC_PH_DONE  = 9'h020,
      LIC_PH_SINK  = 9'h040,
      LIC_PH_CLOSE = 9'h080,
      LIC_PH_FAULT = 9'h100
   } lic_phase_e;

   typedef enum logic [2:0] {
      LIC_CUR_OFF   = 3'h0,
      LIC_CUR_SHORT = 3'h1,
      LIC_CUR_PRE   = 3'h2,
      LIC_CUR_FAST  = 3'h3,
      LIC_CUR_CV    = 3'h4,
      LIC_CUR_SINK  = 3'h5
   } lic_cur_e;

   typedef enum logic [1:0] {
      LIC_TGT_FIXED = 2'h0,
      LIC_TGT_TRACK = 2'h1,
      LIC_TGT_CLAMP = 2'h2
   } lic_tgt_e;
endpackage : lic_pkg

// File: core/lic_sync.sv
// two-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
module lic_sync #(
   parameter int W = 1
)(
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // one pair of flops per bit; the first flop feeds only the second
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               meta[i] <= 1'b0;
               q[i]    <= 1'b0;
            end else begin
               meta[i] <= d[i];
               q[i]    <= meta[i];
            end
         end
      end
   endgenerate
endmodule : lic_sync

// File: core/lic_timer.sv
// interval counter that pulses once each time the limit is reached
`timescale 1ns/1ps
`include "lic_consts.svh"
module lic_timer (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  clear,
   input  wire logic                  count_en,
   input  wire logic [`LIC_TMR_W-1:0] limit,
   output logic                       expired
);
   logic [`LIC_TMR_W-1:0] cnt;

   // counter restarts from zero whenever cleared or idle
   always_ff @(posedge clk_sys) begin
      if (rst || clear || !count_en) begin
         cnt     <= '0;
         expired <= 1'b0;
      end else if (cnt >= limit - `LIC_TMR_W'(1)) begin
         cnt     <= '0;
         expired <= 1'b1;
      end else begin
         cnt     <= cnt + `LIC_TMR_W'(1);
         expired <= 1'b0;
      end
   end
endmodule : lic_timer

// File: core/lic_ctrl.sv
// control logic of a single-cell linear charger with power-path management
`timescale 1ns/1ps
`include "lic_consts.svh"
// Summary of operation
// - fixed low, fixed high, resistor input limits
// - sel_a high, sel_b low selects high
// - input droop cuts limit in usb modes
// - system load served before charging
// - output droop sharing suppresses termination
// - battery switch full on between thresholds
// - no termination during battery supplement
// - supplement short: off, recover, retry
// - no input: short cycling until cleared
// - tracking target, clamp below 3.2 V
// - short check before any charging from idle
// - precharge, fast charge, constant voltage order
// - termination current releases status output
// - regulation loops disable termination
// - input-limited charge slows safety timers
// - termination scale by limit mode
// - termination disable: stay CV, no timers
// - disabled termination: release status until restart
// - disable temperature sensing when pin open and termination disabled
// - recharge threshold starts battery detection
// - detection sink then decide charge or close
// - protector close then charge or repeat
// - disconnect: battery switch off, status low
// - suspend: input switch off, battery on
// - safety fault blinks status at 2 Hz
module lic_ctrl
   import lic_pkg::*;
#(
   parameter bit          TRACK_VARIANT = 1'b0,
   parameter bit          TERM_PROG     = 1'b0,
   parameter int unsigned SC_DGL_CYC    =
      (`LIC_SC_DGL_NS + `LIC_CLK_PERIOD_NS - 1) / `LIC_CLK_PERIOD_NS,
   parameter int unsigned SC_REC_CYC    =
      (`LIC_SC_REC_NS + `LIC_CLK_PERIOD_NS - 1) / `LIC_CLK_PERIOD_NS,
   parameter int unsigned DET_CYC       =
      (`LIC_DET_NS + `LIC_CLK_PERIOD_NS - 1) / `LIC_CLK_PERIOD_NS,
   parameter int unsigned BLINK_CYC     = `LIC_BLINK_HALF_NS / `LIC_CLK_PERIOD_NS
)(
   input  wire logic     clk_sys,
   input  wire logic     rst,
   input  wire lic_cmp_s pins,
   output lic_lim_e      limit_mode,
   output logic          input_limit_reduce,
   output logic          input_switch_on,
   output logic          battery_switch_on,
   output logic          battery_switch_full,
   output logic          sharing_active,
   output logic          supplement_active,
   output logic          short_off,
   output lic_cur_e      charge_current_sel,
   output lic_phase_e    charge_phase,
   output logic          term_detect_en,
   output logic          term_scale_hi,
   output logic          term_use_default,
   output logic          safety_timer_en,
   output logic          timer_slow,
   output logic          temp_sense_en,
   output lic_tgt_e      out_target_sel,
   output logic          charge_status_n_out,
   output logic          charge_status_n_oe,
   output logic          input_valid_n_out,
   output logic          input_valid_n_oe
);
   lic_cmp_s   s;
   lic_phase_e next_phase;
   logic       suspend;
   logic       stop;
   logic       usb_mode;
   logic       term_ok;
   logic       next_supplement;
   logic       dgl_done;
   logic       rec_done;
   logic       det_done;
   logic       blink_tick;
   logic       first_cycle;
   logic       td_release;
   logic       blink;
   logic       charging;

   // every pin and comparator passes two flops first
   lic_sync #(.W($bits(lic_cmp_s))) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d       (pins),
      .q       (s)
   );

   // pin decode shared by several processes
   assign suspend  = s.limit_sel_a & s.limit_sel_b;
   assign stop     = !s.input_present | suspend | s.charge_enable_n;
   assign usb_mode = !s.limit_sel_b;
   // any loop that trims the charge rate blocks termination
   assign term_ok  = !(s.input_present & s.out_at_share) & !next_supplement
                   & !s.thermal_reg & !(usb_mode & s.vin_at_droop);
   assign charging = (charge_phase == LIC_PH_SHORT) | (charge_phase == LIC_PH_PRE)
                   | (charge_phase == LIC_PH_FAST)  | (charge_phase == LIC_PH_CV);

   // input limit mode straight from the select pins
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         limit_mode <= LIC_LIM_SUSP_E;
      end else begin
         case ({s.limit_sel_b, s.limit_sel_a})
            2'h0:    limit_mode <= LIC_LIM_LOW_E;
            2'h1:    limit_mode <= LIC_LIM_HIGH_E;
            2'h2:    limit_mode <= LIC_LIM_RES_E;
            default: limit_mode <= LIC_LIM_SUSP_E;
         endcase
      end
   end

   // input droop only guards the current-limited usb modes
   always_ff @(posedge clk_sys) begin
      if (rst) input_limit_reduce <= 1'b0;
      else     input_limit_reduce <= s.input_present & usb_mode & s.vin_at_droop;
   end

   // output droop sharing trims charge current first
   always_ff @(posedge clk_sys) begin
      if (rst) sharing_active <= 1'b0;
      else     sharing_active <= s.input_present & !suspend & s.out_at_share;
   end

   // supplement has hysteresis between enter and exit thresholds
   always_comb begin
      next_supplement = supplement_active;
      if (!s.input_present || suspend) begin
         next_supplement = 1'b0;
      end else if (s.out_below_sup_enter) begin
         next_supplement = 1'b1;
      end else if (s.out_above_sup_exit) begin
         next_supplement = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) supplement_active <= 1'b0;
      else     supplement_active <= next_supplement;
   end

   // deglitch runs only while the overload persists unsupervised by the input
   lic_timer u_dgl (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clear    (short_off),
      .count_en (s.out_short & (supplement_active | !s.input_present)),
      .limit    (`LIC_TMR_W'(SC_DGL_CYC)),
      .expired  (dgl_done)
   );

   // recovery wait before the output tries again
   lic_timer u_rec (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clear    (!short_off),
      .count_en (short_off),
      .limit    (`LIC_TMR_W'(SC_REC_CYC)),
      .expired  (rec_done)
   );

   // off/retry cycle; a lasting short restarts the deglitch after each retry
   always_ff @(posedge clk_sys) begin
      if (rst)           short_off <= `LIC_RST_OFF;
      else if (dgl_done) short_off <= 1'b1;
      else if (rec_done) short_off <= 1'b0;
   end

   // switches: suspend keeps the battery on the output, short turns both off
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         input_switch_on     <= `LIC_RST_OFF;
         battery_switch_on   <= `LIC_RST_OFF;
         battery_switch_full <= 1'b0;
      end else begin
         input_switch_on     <= s.input_present & !suspend & !short_off;
         battery_switch_on   <= !s.battery_disconnect & !short_off;
         battery_switch_full <= !s.battery_disconnect & !short_off
                              & (next_supplement | !s.input_present);
      end
   end

   // charge sequence
   always_comb begin
      next_phase = charge_phase;
      case (charge_phase)
         LIC_PH_IDLE:
            next_phase = LIC_PH_SHORT;
         LIC_PH_SHORT:
            if (s.battery_above_short_chk) next_phase = LIC_PH_PRE;
         LIC_PH_PRE:
            if (s.safety_timer_expired && !s.termination_disable) begin
               next_phase = LIC_PH_FAULT;
            end else if (s.battery_above_pre_exit) begin
               next_phase = LIC_PH_FAST;
            end
         LIC_PH_FAST:
            if (s.safety_timer_expired && !s.termination_disable) begin
               next_phase = LIC_PH_FAULT;
            end else if (s.battery_at_reg) begin
               next_phase = LIC_PH_CV;
            end
         LIC_PH_CV:
            // with termination disabled the phase is left only on stop
            if (!s.termination_disable && term_ok && s.current_at_term) begin
               next_phase = LIC_PH_DONE;
            end
         LIC_PH_DONE:
            if (s.battery_below_recharge) next_phase = LIC_PH_SINK;
         LIC_PH_SINK:
            if (det_done) begin
               next_phase = s.battery_above_pre_exit ? LIC_PH_PRE : LIC_PH_CLOSE;
            end
         LIC_PH_CLOSE:
            if (det_done) begin
               next_phase = s.battery_below_recharge ? LIC_PH_PRE : LIC_PH_SINK;
            end
         LIC_PH_FAULT:
            next_phase = LIC_PH_FAULT;
         default:
            next_phase = LIC_PH_IDLE;
      endcase
      // power loss, suspend or charge disable abandon any phase
      if (stop) next_phase = LIC_PH_IDLE;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) charge_phase <= LIC_PH_IDLE;
      else     charge_phase <= next_phase;
   end

   // detection interval, restarted at every phase change
   lic_timer u_det (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clear    (next_phase != charge_phase),
      .count_en ((charge_phase == LIC_PH_SINK) | (charge_phase == LIC_PH_CLOSE)),
      .limit    (`LIC_TMR_W'(DET_CYC)),
      .expired  (det_done)
   );

   // current source selection follows the phase being entered
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         charge_current_sel <= LIC_CUR_OFF;
      end else begin
         case (next_phase)
            LIC_PH_SHORT: charge_current_sel <= LIC_CUR_SHORT;
            LIC_PH_PRE:   charge_current_sel <= LIC_CUR_PRE;
            LIC_PH_FAST:  charge_current_sel <= LIC_CUR_FAST;
            LIC_PH_CV:    charge_current_sel <= LIC_CUR_CV;
            LIC_PH_SINK:  charge_current_sel <= LIC_CUR_SINK;
            LIC_PH_CLOSE: charge_current_sel <= LIC_CUR_PRE;
            default:      charge_current_sel <= LIC_CUR_OFF;
         endcase
      end
   end

   // termination detection and its scale
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         term_detect_en   <= 1'b0;
         term_scale_hi    <= 1'b0;
         term_use_default <= 1'b1;
      end else begin
         term_detect_en   <= (charge_phase == LIC_PH_CV) & !s.termination_disable & term_ok;
         term_scale_hi    <= s.limit_sel_a | s.limit_sel_b;
         term_use_default <= !TERM_PROG | s.term_pin_open;
      end
   end

   // safety timers run in precharge and fast charge only
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         safety_timer_en <= 1'b0;
         timer_slow      <= 1'b0;
      end else begin
         safety_timer_en <= ((next_phase == LIC_PH_PRE) | (next_phase == LIC_PH_FAST))
                          & !s.termination_disable;
         // slowing tracks the reduced charge rate
         timer_slow      <= s.fast_exceeds_limit | s.thermal_reg
                          | (s.input_present & s.out_at_share)
                          | (usb_mode & s.vin_at_droop);
      end
   end

   // temperature sensing and output voltage target
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         temp_sense_en  <= 1'b0;
         out_target_sel <= LIC_TGT_FIXED;
      end else begin
         temp_sense_en  <= !(s.termination_disable & s.temp_pin_open_or_high);
         if (!TRACK_VARIANT)           out_target_sel <= LIC_TGT_FIXED;
         else if (s.battery_below_3v2) out_target_sel <= LIC_TGT_CLAMP;
         else                          out_target_sel <= LIC_TGT_TRACK;
      end
   end

   // first cycle after a restart shows charging; refresh cycles stay dark
   always_ff @(posedge clk_sys) begin
      if (rst)                             first_cycle <= 1'b0;
      else if (charge_phase == LIC_PH_IDLE) first_cycle <= 1'b1;
      else if (next_phase == LIC_PH_DONE)  first_cycle <= 1'b0;
   end

   // latched release, only a restart through idle clears it
   always_ff @(posedge clk_sys) begin
      if (rst || stop) begin
         td_release <= 1'b0;
      end else if (charge_phase == LIC_PH_CV && s.termination_disable
                   && s.current_at_term) begin
         td_release <= 1'b1;
      end
   end

   // half period of the fault flash
   lic_timer u_blink (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clear    (1'b0),
      .count_en (charge_phase == LIC_PH_FAULT),
      .limit    (`LIC_TMR_W'(BLINK_CYC)),
      .expired  (blink_tick)
   );

   always_ff @(posedge clk_sys) begin
      if (rst || charge_phase != LIC_PH_FAULT) blink <= 1'b1;
      else if (blink_tick)                    blink <= !blink;
   end

   // open-drain status pins: enable high pulls the pin low
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         charge_status_n_out <= 1'b0;
         charge_status_n_oe  <= 1'b0;
         input_valid_n_out   <= 1'b0;
         input_valid_n_oe    <= 1'b0;
      end else begin
         charge_status_n_out <= 1'b0;
         input_valid_n_out   <= 1'b0;
         input_valid_n_oe    <= s.input_present;
         if (s.battery_disconnect)
            charge_status_n_oe <= 1'b1;
         else if (charge_phase == LIC_PH_FAULT)
            charge_status_n_oe <= blink;
         else
            charge_status_n_oe <= charging & first_cycle & !td_release;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_suspend_input_off: assert property (suspend |=> !input_switch_on)
      else $error("input switch on during suspend");
   a_high_usb_mode: assert property ((s.limit_sel_a && !s.limit_sel_b)
      |=> limit_mode == LIC_LIM_HIGH_E)
      else $error("high usb mode not selected");
   a_droop_usb_only: assert property (input_limit_reduce
      |-> limit_mode inside {LIC_LIM_LOW_E, LIC_LIM_HIGH_E})
      else $error("input droop acting outside usb modes");
   a_share_no_term: assert property (sharing_active |-> !term_detect_en)
      else $error("termination enabled while sharing");
   a_supp_no_term: assert property (supplement_active |-> !term_detect_en)
      else $error("termination enabled during supplement");
   a_short_both_off: assert property ($rose(short_off)
      |=> !input_switch_on && !battery_switch_on && !battery_switch_full)
      else $error("output not switched off on short");
   a_short_retry: assert property (short_off && rec_done |=> !short_off)
      else $error("no retry after recovery");
   a_short_check: assert property (charge_phase == LIC_PH_SHORT && !stop
      && !s.battery_above_short_chk |=> charge_phase == LIC_PH_SHORT)
      else $error("charging left short check early");
   a_disc_status_low: assert property (s.battery_disconnect
      |=> !battery_switch_on && charge_status_n_oe)
      else $error("disconnect not honoured");
   a_td_timers_off: assert property (s.termination_disable |=> !safety_timer_en)
      else $error("safety timers on with termination disabled");
   a_td_stays_cv: assert property (charge_phase == LIC_PH_CV && s.termination_disable
      && !stop |=> charge_phase == LIC_PH_CV)
      else $error("left constant voltage with termination disabled");
endmodule : lic_ctrl

// File: dv/lic_pack_model.sv
// behavioural battery pack answering the charger's current selection
`timescale 1ns/1ps
module lic_pack_model
   import lic_pkg::*;
(
   input  wire logic     clk_sys,
   input  wire logic     rst,
   input  wire lic_cur_e cur,
   input  wire logic     missing,
   output lic_cmp_s      battery_node
);
   int v;
   int taper;
   int slow;
   // cell voltage in steps: rises while fed, sags slowly when idle or sunk
   always_ff @(posedge clk_sys) begin
      slow <= slow + 1;
      if (rst) begin
         slow <= 0;
         v <= 0;
         taper <= 0;
      end else if (missing) begin
         // an absent cell collapses under sink current and floats high when fed
         v <= (cur == LIC_CUR_SINK) ? 0 : 14;
      end else if (cur inside {LIC_CUR_SHORT, LIC_CUR_PRE, LIC_CUR_FAST}) begin
         v <= (v < 12) ? v + 1 : 12;
      end else if (cur == LIC_CUR_CV) begin
         taper <= (taper < 6) ? taper + 1 : 6;
      end else if (slow[2:0] == 3'h0 && v > 0) begin
         v <= v - 1;
         taper <= 0;
      end
   end
   // comparator view of the cell, only battery bits are driven here
   always_comb begin
      battery_node = '0;
      battery_node.battery_above_short_chk = (v > 2);
      battery_node.battery_above_pre_exit  = (v > 6);
      battery_node.battery_at_reg          = (v >= 12);
      battery_node.current_at_term         = (taper >= 6);
      battery_node.battery_below_recharge  = (v < 10);
   end
endmodule : lic_pack_model

// File: dv/li_ion_charge_power_path_ctrl_tb_top.sv
// self-checking bench of the charger control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module li_ion_charge_power_path_ctrl_tb_top
   import lic_pkg::*;
;
   typedef struct packed {
      logic [1:0] sel;
      logic       droop;
      logic       low3v2;
      lic_lim_e   mode;
      logic       red;
      logic       insw;
      logic       scale;
      lic_tgt_e   tgt;
   } lic_row_s;
   localparam int DGL = 8;
   localparam int REC = 20;
   localparam int DET = 12;
   localparam int BLK = 16;
   logic       clk_sys, rst, missing, s;
   lic_cmp_s   host, battery_node, pins;
   int         errors, checked;
   lic_row_s   rows [6];
   lic_lim_e   limit_mode;
   lic_cur_e   charge_current_sel;
   lic_phase_e charge_phase;
   lic_tgt_e   out_target_sel;
   logic       input_limit_reduce, input_switch_on, battery_switch_on, battery_switch_full;
   logic       sharing_active, supplement_active, short_off, term_detect_en, term_scale_hi;
   logic       safety_timer_en, timer_slow, temp_sense_en, charge_status_n_oe;
   logic       term_use_default, charge_status_n_out, input_valid_n_out, input_valid_n_oe;
   // pins seen by the block: host levels merged with the pack's battery bits
   assign pins = host | battery_node;
   lic_ctrl #(.TRACK_VARIANT(1'b1), .TERM_PROG(1'b1), .SC_DGL_CYC(DGL), .SC_REC_CYC(REC),
      .DET_CYC(DET), .BLINK_CYC(BLK)) i_dut (.clk_sys, .rst, .pins, .limit_mode,
      .input_limit_reduce, .input_switch_on, .battery_switch_on, .battery_switch_full,
      .sharing_active, .supplement_active, .short_off, .charge_current_sel, .charge_phase,
      .term_detect_en, .term_scale_hi, .term_use_default, .safety_timer_en, .timer_slow,
      .temp_sense_en, .out_target_sel, .charge_status_n_out, .charge_status_n_oe,
      .input_valid_n_out, .input_valid_n_oe);
   lic_pack_model i_pack (.clk_sys, .rst, .cur(charge_current_sel), .missing, .battery_node);
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask : tick
   task automatic wait_phase(input lic_phase_e ph, input int lim);
      for (int k = 0; k < lim && charge_phase !== ph; k++) tick(1);
      `CHK("charge_phase", ph, charge_phase)
   endtask : wait_phase
   task automatic wait_short(input logic v, input int lim);
      for (int k = 0; k < lim && short_off !== v; k++) tick(1);
      `CHK("short_off", v, short_off)
   endtask : wait_short
   task automatic tally_and_finish();
      if (errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   // a hung wait must not stall the run; the whole sequence needs about 400 cycles
   initial begin
      #(25 * 6000);
      errors++;
      tally_and_finish();
   end
   initial begin
      errors = 0;
      checked = 0;
      missing = 1'b0;
      rst = 1'b1;
      host = '0;
      host.charge_enable_n = 1'b1;
      rows = '{'{2'h0, 1'h0, 1'h0, LIC_LIM_LOW_E, 1'h0, 1'h1, 1'h0, LIC_TGT_TRACK},
               '{2'h0, 1'h1, 1'h1, LIC_LIM_LOW_E, 1'h1, 1'h1, 1'h0, LIC_TGT_CLAMP},
               '{2'h1, 1'h0, 1'h0, LIC_LIM_HIGH_E, 1'h0, 1'h1, 1'h1, LIC_TGT_TRACK},
               '{2'h1, 1'h1, 1'h1, LIC_LIM_HIGH_E, 1'h1, 1'h1, 1'h1, LIC_TGT_CLAMP},
               '{2'h2, 1'h1, 1'h0, LIC_LIM_RES_E, 1'h0, 1'h1, 1'h1, LIC_TGT_TRACK},
               '{2'h3, 1'h1, 1'h0, LIC_LIM_SUSP_E, 1'h0, 1'h0, 1'h1, LIC_TGT_TRACK}};
      tick(6);
      `CHK("charge_phase", LIC_PH_IDLE, charge_phase)
      `CHK("input_switch_on", 1'b0, input_switch_on)
      `CHK("short_off", 1'b0, short_off)
      `CHK("charge_current_sel", LIC_CUR_OFF, charge_current_sel)
      rst = 1'b0;
      host.input_present = 1'b1;
      // limit modes with and without input droop and the low-battery clamp
      foreach (rows[i]) begin
         {host.limit_sel_b, host.limit_sel_a} = rows[i].sel;
         host.vin_at_droop = rows[i].droop;
         host.battery_below_3v2 = rows[i].low3v2;
         tick(4);
         `CHK("limit_mode", rows[i].mode, limit_mode)
         `CHK("input_limit_reduce", rows[i].red, input_limit_reduce)
         `CHK("input_switch_on", rows[i].insw, input_switch_on)
         `CHK("input_valid_n_oe", 1'b1, input_valid_n_oe)
         if (rows[i].mode == LIC_LIM_SUSP_E) `CHK("battery_switch_on", 1'b1, battery_switch_on)
         else `CHK("term_scale_hi", rows[i].scale, term_scale_hi)
         if (rows[i].mode != LIC_LIM_SUSP_E) `CHK("out_target_sel", rows[i].tgt, out_target_sel)
      end
      {host.limit_sel_b, host.limit_sel_a, host.vin_at_droop} = 3'h2;
      host.charge_enable_n = 1'b0;
      wait_phase(LIC_PH_SHORT, 8);
      `CHK("charge_current_sel", LIC_CUR_SHORT, charge_current_sel)
      wait_phase(LIC_PH_PRE, 20);
      `CHK("charge_status_n_oe", 1'b1, charge_status_n_oe)
      `CHK("status_out", 2'h0, {charge_status_n_out, input_valid_n_out})
      `CHK("term_use_default", 1'b0, term_use_default)
      wait_phase(LIC_PH_FAST, 20);
      host.fast_exceeds_limit = 1'b1;
      tick(4);
      `CHK("timer_slow", 1'b1, timer_slow)
      host.fast_exceeds_limit = 1'b0;
      wait_phase(LIC_PH_CV, 30);
      tick(1);
      `CHK("term_detect_en", 1'b1, term_detect_en)
      // each regulation loop in turn holds off termination while the taper is done
      for (int i = 0; i < 4; i++) begin
         host.out_at_share = (i == 0);
         host.thermal_reg = (i == 1);
         host.vin_at_droop = (i == 2);
         host.out_below_sup_enter = (i == 3);
         tick(10);
         if (i == 0) `CHK("sharing_active", 1'b1, sharing_active)
         if (i == 3) `CHK("supplement_active", 1'b1, supplement_active)
         `CHK("term_detect_en", 1'b0, term_detect_en)
         `CHK("charge_phase", LIC_PH_CV, charge_phase)
      end
      {host.out_below_sup_enter, host.out_above_sup_exit} = 2'h1;
      wait_phase(LIC_PH_DONE, 10);
      host.out_above_sup_exit = 1'b0;
      tick(2);
      `CHK("charge_status_n_oe", 1'b0, charge_status_n_oe)
      wait_phase(LIC_PH_SINK, 80);
      wait_phase(LIC_PH_PRE, DET + 10);
      wait_phase(LIC_PH_SINK, 300);
      missing = 1'b1;
      wait_phase(LIC_PH_CLOSE, DET + 10);
      wait_phase(LIC_PH_SINK, DET + 10);
      host.charge_enable_n = 1'b1;
      missing = 1'b0;
      wait_phase(LIC_PH_IDLE, 6);
      // battery supplement, then a short that keeps cycling the output
      host.out_below_sup_enter = 1'b1;
      tick(4);
      `CHK("supplement_active", 1'b1, supplement_active)
      `CHK("battery_switch_full", 1'b1, battery_switch_full)
      `CHK("term_detect_en", 1'b0, term_detect_en)
      host.out_short = 1'b1;
      tick(DGL);
      `CHK("short_off", 1'b0, short_off)
      wait_short(1'b1, 8);
      tick(2);
      `CHK("input_switch_on", 1'b0, input_switch_on)
      `CHK("battery_switch_on", 1'b0, battery_switch_on)
      wait_short(1'b0, REC + 4);
      wait_short(1'b1, DGL + 6);
      {host.out_short, host.out_below_sup_enter, host.out_above_sup_exit} = 3'h1;
      wait_short(1'b0, REC + 4);
      tick(4);
      `CHK("supplement_active", 1'b0, supplement_active)
      host.out_above_sup_exit = 1'b0;
      host.input_present = 1'b0;
      host.out_short = 1'b1;
      wait_short(1'b1, DGL + 6);
      host.out_short = 1'b0;
      wait_short(1'b0, REC + 4);
      host.input_present = 1'b1;
      {host.termination_disable, host.temp_pin_open_or_high} = 2'h3;
      host.charge_enable_n = 1'b0;
      wait_phase(LIC_PH_CV, 60);
      tick(12);
      `CHK("charge_phase", LIC_PH_CV, charge_phase)
      `CHK("safety_timer_en", 1'b0, safety_timer_en)
      `CHK("temp_sense_en", 1'b0, temp_sense_en)
      `CHK("charge_status_n_oe", 1'b0, charge_status_n_oe)
      host.battery_disconnect = 1'b1;
      tick(4);
      `CHK("battery_switch_on", 1'b0, battery_switch_on)
      `CHK("charge_status_n_oe", 1'b1, charge_status_n_oe)
      {host.battery_disconnect, host.termination_disable, host.charge_enable_n} = 3'h1;
      host.safety_timer_expired = 1'b1;
      tick(4);
      host.charge_enable_n = 1'b0;
      wait_phase(LIC_PH_FAULT, 20);
      tick(4);
      s = charge_status_n_oe;
      tick(BLK);
      `CHK("charge_status_n_oe", ~s, charge_status_n_oe)
      tick(BLK);
      `CHK("charge_status_n_oe", s, charge_status_n_oe)
      tally_and_finish();
   end
endmodule : li_ion_charge_power_path_ctrl_tb_top
